/* rtl/stc_timer.sv */
// Summary of operation
// - Sixteen-bit count from two readable, writable bytes, counting up and wrapping.
// - Overflow latches the flag; the interrupt fires only when enabled.
// - Control bit 1 picks external rising edges or the quarter-rate clock.
// - Control bit 0 runs counting; clearing it holds the count.
// - Control bits 5:4 pick prescale 1:1, 1:2, 1:4 or 1:8.
// - Control bit 3 powers the oscillator; clear powers its inverter down.
// - Oscillator on forces both its pins to inputs reading zero.
// - Control bit 2 chooses synchronised or raw external clock; ignored internally.
// - External edges come from oscillator input pin or external clock pin.
// - The prescaler sits ahead of the synchronisation stage.
// - Synchronised counting stops in sleep while the prescaler keeps counting external edges.
// - Unsynchronised counting continues in sleep and overflow can wake.
// - Unsynchronised mode offers no time base to capture or compare.
// - Either compare module's trigger clears the count.
// - A trigger clear never sets the overflow flag.
// - A count write coinciding with a trigger wins over it.
// - Writing either count byte clears the prescaler.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
module stc_timer (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rd_data_out,
   input wire logic sleep_in,
   input wire logic [1:0] trigger_in,
   input wire logic osc_input_pin_in,
   input wire logic ext_clock_pin_in,
   input wire logic [1:0] port_direction_bits_in,
   output logic [1:0] port_direction_eff_out,
   output logic [1:0] port_pins_read_out,
   output logic osc_amp_enable_out,
   output logic irq_out,
   output logic wake_out,
   output logic [15:0] count_out,
   output logic timebase_valid_out
);

   typedef struct packed {
      logic [5:0] ctrl;
      logic [15:0] cnt;
      logic flag;
      logic ien;
      logic [2:0] pre;
      logic [1:0] div;
      logic [1:0] pin_s1;
      logic [1:0] pin_s2;
      logic edge_prev;
      logic sync_tick;
      logic [7:0] rdata;
   } stc_state_t;

   stc_state_t s_reg;
   stc_state_t s_next;

   logic rst_q1_reg;
   logic rst_n;
   logic osc_en;
   logic src_ext;
   logic async_mode;
   logic running;
   logic ext_level;
   logic ext_rise;
   logic instr_tick;
   logic src_tick;
   logic pre_tick;
   logic pre_done;
   logic inc;
   logic trig;
   logic wr_low;
   logic wr_high;
   logic wr_cnt;
   logic wr_flag;
   logic [2:0] ps_mask;

   // Reset is released through two flops so every state flop leaves
   // reset on the same edge.
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_q1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1_reg <= 1'b1;
         rst_n <= rst_q1_reg;
      end
   end

   assign osc_en = s_reg.ctrl[stc_pkg::CTL_OSC];
   assign src_ext = s_reg.ctrl[stc_pkg::CTL_SRC];
   assign running = s_reg.ctrl[stc_pkg::CTL_ON];
   // The no-sync bit only matters when the external source is picked.
   assign async_mode = src_ext & s_reg.ctrl[stc_pkg::CTL_NOSYNC];
   assign ps_mask = stc_pkg::stc_ps_mask(
      s_reg.ctrl[stc_pkg::CTL_PS_HI:stc_pkg::CTL_PS_LO]);

   // Only the second synchroniser stage is looked at.
   assign ext_level = osc_en ? s_reg.pin_s2[stc_pkg::PIN_OSI]
                             : s_reg.pin_s2[stc_pkg::PIN_CKI];
   assign ext_rise = ext_level & ~s_reg.edge_prev;
   // The instruction clock halts in sleep, so timer mode freezes there.
   assign instr_tick = (s_reg.div == stc_pkg::DIV_LAST) & ~sleep_in;
   assign src_tick = src_ext ? ext_rise : instr_tick;
   assign pre_tick = running & src_tick;
   assign pre_done = pre_tick & ((s_reg.pre & ps_mask) == ps_mask);

   // In synchronised modes the prescaled tick passes one more flop stage,
   // which is switched off in sleep; the raw path bypasses it.
   assign inc = async_mode ? pre_done
              : (s_reg.sync_tick & ~sleep_in & running);

   assign trig = |trigger_in;
   assign wr_low = wr_in & (addr_in == stc_pkg::ADDR_LOW);
   assign wr_high = wr_in & (addr_in == stc_pkg::ADDR_HIGH);
   assign wr_cnt = wr_low | wr_high;
   assign wr_flag = wr_in & (addr_in == stc_pkg::ADDR_FLAG);

   always_comb begin
      s_next = s_reg;
      s_next.pin_s1 = {osc_input_pin_in, ext_clock_pin_in};
      s_next.pin_s2 = s_reg.pin_s1;
      s_next.edge_prev = ext_level;
      s_next.div = s_reg.div + stc_pkg::DIV_ONE;
      s_next.sync_tick = pre_done & ~async_mode;

      if (wr_cnt) begin
         s_next.pre = stc_pkg::PRE_ZERO;
      end else if (pre_tick) begin
         s_next.pre = s_reg.pre + stc_pkg::PRE_ONE;
      end

      if (wr_flag) begin
         s_next.flag = wr_data_in[stc_pkg::FLAG_BIT];
      end
      if (wr_in && addr_in == stc_pkg::ADDR_IEN) begin
         s_next.ien = wr_data_in[stc_pkg::FLAG_BIT];
      end
      if (wr_in && addr_in == stc_pkg::ADDR_CTRL) begin
         s_next.ctrl = wr_data_in[stc_pkg::CTL_W-1:0];
      end

      // A write beats both the trigger and an increment in its cycle.
      if (wr_cnt) begin
         if (wr_low) begin
            s_next.cnt[7:0] = wr_data_in;
         end
         if (wr_high) begin
            s_next.cnt[15:8] = wr_data_in;
         end
      end else if (trig) begin
         s_next.cnt = stc_pkg::CNT_ZERO;
      end else if (inc) begin
         s_next.cnt = s_reg.cnt + stc_pkg::CNT_ONE;
         if (s_reg.cnt == stc_pkg::CNT_MAX) begin
            // Set wins over a software clear in the same cycle.
            s_next.flag = 1'b1;
         end
      end

      s_next.rdata = stc_pkg::BYTE_ZERO;
      if (rd_in) begin
         case (addr_in)
            stc_pkg::ADDR_LOW: s_next.rdata = s_reg.cnt[7:0];
            stc_pkg::ADDR_HIGH: s_next.rdata = s_reg.cnt[15:8];
            stc_pkg::ADDR_CTRL: begin
               s_next.rdata = {stc_pkg::CTRL_UNUSED, s_reg.ctrl};
            end
            stc_pkg::ADDR_FLAG: begin
               s_next.rdata = {stc_pkg::FLAG_PAD, s_reg.flag};
            end
            stc_pkg::ADDR_IEN: begin
               s_next.rdata = {stc_pkg::FLAG_PAD, s_reg.ien};
            end
            default: s_next.rdata = stc_pkg::BYTE_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else if (ce_in) begin
         s_reg <= s_next;
      end
   end

   assign rd_data_out = s_reg.rdata;
   assign count_out = s_reg.cnt;
   // Raw external counts are not safe to sample from another module.
   assign timebase_valid_out = ~async_mode;
   assign osc_amp_enable_out = osc_en;
   assign port_direction_eff_out = osc_en ? stc_pkg::PINS_INPUT
                                          : port_direction_bits_in;
   assign port_pins_read_out = osc_en ? stc_pkg::PINS_ZERO
                                      : s_reg.pin_s2;
   assign irq_out = s_reg.flag & s_reg.ien;
   assign wake_out = irq_out & sleep_in;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n);

   sequence s_clean_step;
      ce_in && !wr_cnt && !trig;
   endsequence

   sequence s_wrap;
      s_clean_step ##0 inc && s_reg.cnt == stc_pkg::CNT_MAX;
   endsequence

   a_wrap_to_zero: assert property (s_wrap |=> s_reg.cnt == stc_pkg::CNT_ZERO)
      else $error("Count did not wrap to zero.");

   a_overflow_flag_set: assert property (s_wrap |=> s_reg.flag)
      else $error("Overflow did not set the flag.");

   a_async_wake: assert property (s_wrap ##0 (sleep_in && async_mode
      && s_reg.ien) |=> irq_out && (wake_out || !sleep_in))
      else $error("Overflow in sleep did not wake.");

   a_hold_when_off: assert property (s_clean_step ##0 !running
      |=> s_reg.cnt == $past(s_reg.cnt))
      else $error("Count moved while stopped.");

   a_sleep_sync_hold: assert property (s_clean_step ##0 (sleep_in
      && !async_mode) |=> s_reg.cnt == $past(s_reg.cnt))
      else $error("Synchronised count moved in sleep.");

   a_trigger_clears: assert property (ce_in && trig && !wr_cnt
      |=> s_reg.cnt == stc_pkg::CNT_ZERO)
      else $error("Trigger did not clear the count.");

   a_trigger_no_flag: assert property (ce_in && trig && !s_reg.flag
      && !wr_flag |=> !s_reg.flag)
      else $error("Trigger clear set the flag.");

   a_write_beats_trig: assert property (ce_in && wr_low && !wr_high
      && trig |=> s_reg.cnt[7:0] == $past(wr_data_in)
      && s_reg.cnt[15:8] == $past(s_reg.cnt[15:8]))
      else $error("Write lost against trigger.");

   a_prescale_clear: assert property (ce_in && wr_cnt
      |=> s_reg.pre == stc_pkg::PRE_ZERO)
      else $error("Count write left the prescaler.");

   a_ctrl_upper_zero: assert property (ce_in && rd_in
      && addr_in == stc_pkg::ADDR_CTRL |=> rd_data_out[7:6]
      == stc_pkg::CTRL_UNUSED)
      else $error("Unused control bits read nonzero.");

endmodule : stc_timer

/* rtl/stc_pkg.sv */
package stc_pkg;

   // Register map, byte addresses on the plain register port.
   localparam logic [7:0] ADDR_FLAG = 8'h0c;
   localparam logic [7:0] ADDR_LOW = 8'h0e;
   localparam logic [7:0] ADDR_HIGH = 8'h0f;
   localparam logic [7:0] ADDR_CTRL = 8'h10;
   localparam logic [7:0] ADDR_IEN = 8'h8c;

   // Control register fields.
   localparam int CTL_ON = 0;
   localparam int CTL_SRC = 1;
   localparam int CTL_NOSYNC = 2;
   localparam int CTL_OSC = 3;
   localparam int CTL_PS_LO = 4;
   localparam int CTL_PS_HI = 5;
   localparam int CTL_W = 6;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam logic [1:0] CTRL_UNUSED = 2'h0;

   // Overflow flag and its enable sit in bit 0 of their registers.
   localparam int FLAG_BIT = 0;
   localparam logic [6:0] FLAG_PAD = 7'h00;

   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // Pin order inside the two-bit pin groups.
   localparam int PIN_CKI = 0;
   localparam int PIN_OSI = 1;
   localparam logic [1:0] PINS_INPUT = 2'h3;
   localparam logic [1:0] PINS_ZERO = 2'h0;

   // The instruction clock runs at one quarter of the core clock.
   localparam int CLK_PERIOD_NS = 4;
   localparam int INSTR_DIV = 4;
   localparam logic [1:0] DIV_LAST = 2'(INSTR_DIV - 1);
   localparam logic [1:0] DIV_ONE = 2'h1;
   localparam logic [1:0] DIV_ZERO = 2'h0;

   localparam logic [2:0] PRE_ZERO = 3'h0;
   localparam logic [2:0] PRE_ONE = 3'h1;

   // Low prescaler bits that must all be set before a count is passed on.
   function automatic logic [2:0] stc_ps_mask(input logic [1:0] sel);
      case (sel)
         2'h0: stc_ps_mask = 3'h0;
         2'h1: stc_ps_mask = 3'h1;
         2'h2: stc_ps_mask = 3'h3;
         default: stc_ps_mask = 3'h7;
      endcase
   endfunction : stc_ps_mask

endpackage : stc_pkg

/* dv/stc_ext_src.sv */
`timescale 1ns/10ps
module stc_ext_src #(parameter int HALF_NS = 20) (
   input wire logic run_in,
   output logic pin_out
);
   // The pin rests low between bursts so that no stray edge is counted.
   initial begin
      pin_out = 1'b0;
      forever begin
         #HALF_NS;
         pin_out = run_in ? ~pin_out : 1'b0;
      end
   end
endmodule : stc_ext_src

/* dv/stc_timer_tb.sv */
`timescale 1ns/10ps
module stc_timer_tb;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wr_data_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic sleep_in = 1'b0;
   logic [1:0] trigger_in = 2'h0;
   logic [1:0] dir_in = 2'h1;
   logic run = 1'b0;
   logic ce = 1'b1;
   logic use_osc = 1'b0;
   logic ext_pin;
   logic osc_pin;
   logic cki_pin;
   logic [7:0] rd_data_out;
   logic [1:0] dir_eff;
   logic [1:0] pins_rd;
   logic osc_amp;
   logic irq_out;
   logic wake_out;
   logic [15:0] count_out;
   logic tb_valid;
   logic [15:0] held;
   int error_cnt = 0;
   int tests_run = 0;

   always #2 clk_in = ~clk_in;

   stc_ext_src u_stc_ext_src (.run_in(run), .pin_out(ext_pin));

   // The source is steered to one pin at a time; the other rests low.
   assign osc_pin = use_osc & ext_pin;
   assign cki_pin = ~use_osc & ext_pin;

   stc_timer u_stc_timer (
      .clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
      .rd_in(rd_in), .rd_data_out(rd_data_out), .sleep_in(sleep_in),
      .trigger_in(trigger_in), .osc_input_pin_in(osc_pin),
      .ext_clock_pin_in(cki_pin), .port_direction_bits_in(dir_in),
      .port_direction_eff_out(dir_eff), .port_pins_read_out(pins_rd),
      .osc_amp_enable_out(osc_amp), .irq_out(irq_out),
      .wake_out(wake_out), .count_out(count_out),
      .timebase_valid_out(tb_valid)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk(16'(rd_data_out), 16'(exp));
   endtask : rdc

   // Each burst gives exactly n rising edges on the external pin, since it
   // starts off the source's 20 ns grid and spans exactly 2n toggles.
   task automatic pulses(input int n);
      run = 1'b1;
      #(n * 40);
      run = 1'b0;
      #60;
   endtask : pulses

   task automatic t_regs();
      rdc(stc_pkg::ADDR_CTRL, 8'h00);
      wr(stc_pkg::ADDR_CTRL, 8'hc0);
      rdc(stc_pkg::ADDR_CTRL, 8'h00);
      rdc(8'h55, 8'h00);
      wr(stc_pkg::ADDR_LOW, 8'h34);
      wr(stc_pkg::ADDR_HIGH, 8'h12);
      rdc(stc_pkg::ADDR_LOW, 8'h34);
      wr(stc_pkg::ADDR_LOW, 8'h56);
      rdc(stc_pkg::ADDR_HIGH, 8'h12);
      chk(16'(dir_eff), 16'h0001);
      wr(stc_pkg::ADDR_CTRL, 8'h08);
      chk(16'(osc_amp), 16'h0001);
      chk(16'({dir_eff, pins_rd}), 16'h000c);
      wr(stc_pkg::ADDR_CTRL, 8'h00);
      chk(16'(osc_amp), 16'h0000);
   endtask : t_regs

   task automatic t_wrap();
      wr(stc_pkg::ADDR_LOW, 8'hfe);
      wr(stc_pkg::ADDR_HIGH, 8'hff);
      wr(stc_pkg::ADDR_CTRL, 8'h01);
      for (int n = 0; n < 40 && count_out !== 16'h0000; n++) begin
         @(posedge clk_in);
      end
      #1;
      chk(count_out, 16'h0000);
      rdc(stc_pkg::ADDR_FLAG, 8'h01);
      chk(16'(irq_out), 16'h0000);
      wr(stc_pkg::ADDR_IEN, 8'h01);
      chk(16'(irq_out), 16'h0001);
      sleep_in <= 1'b1;
      #8;
      chk(16'(wake_out), 16'h0001);
      sleep_in <= 1'b0;
      ce <= 1'b0;
      held = count_out;
      repeat (12) @(posedge clk_in);
      #1;
      chk(count_out, held);
      ce <= 1'b1;
      wr(stc_pkg::ADDR_CTRL, 8'h00);
      held = count_out;
      repeat (12) @(posedge clk_in);
      #1;
      chk(count_out, held);
      wr(stc_pkg::ADDR_FLAG, 8'h00);
   endtask : t_wrap

   task automatic t_trig();
      wr(stc_pkg::ADDR_LOW, 8'hff);
      wr(stc_pkg::ADDR_HIGH, 8'hff);
      @(posedge clk_in);
      trigger_in <= 2'h1;
      @(posedge clk_in);
      trigger_in <= 2'h0;
      #5;
      chk(count_out, 16'h0000);
      rdc(stc_pkg::ADDR_FLAG, 8'h00);
      wr(stc_pkg::ADDR_HIGH, 8'h12);
      @(posedge clk_in);
      addr_in <= stc_pkg::ADDR_LOW;
      wr_data_in <= 8'h77;
      wr_in <= 1'b1;
      trigger_in <= 2'h2;
      @(posedge clk_in);
      wr_in <= 1'b0;
      trigger_in <= 2'h0;
      #5;
      chk(count_out, 16'h1277);
   endtask : t_trig

   task automatic t_ext();
      // Writing the count clears the prescaler, so every ratio starts clean.
      for (int i = 0; i < 4; i++) begin
         wr(stc_pkg::ADDR_LOW, 8'h00);
         wr(stc_pkg::ADDR_HIGH, 8'h00);
         wr(stc_pkg::ADDR_CTRL, 8'((i << 4) | 3));
         pulses(8);
         chk(count_out, 16'(8 >> i));
      end
      wr(stc_pkg::ADDR_CTRL, 8'h03);
      wr(stc_pkg::ADDR_LOW, 8'h00);
      sleep_in <= 1'b1;
      pulses(4);
      chk(count_out, 16'h0000);
      chk(16'(tb_valid), 16'h0001);
      wr(stc_pkg::ADDR_CTRL, 8'h07);
      wr(stc_pkg::ADDR_LOW, 8'h00);
      chk(16'(tb_valid), 16'h0000);
      pulses(4);
      chk(count_out, 16'h0004);
      sleep_in <= 1'b0;
      use_osc = 1'b1;
      wr(stc_pkg::ADDR_CTRL, 8'h0b);
      wr(stc_pkg::ADDR_LOW, 8'h00);
      pulses(4);
      chk(count_out, 16'h0004);
      use_osc = 1'b0;
   endtask : t_ext

   task automatic summarize();
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   initial begin
      repeat (10) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      t_regs();
      t_wrap();
      t_trig();
      t_ext();
      summarize();
   end

   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
endmodule : stc_timer_tb
